// File: rtl/sac_cfg_regs.sv
// control-word bank: aux divider, third word and optional words
// Summary of operation
// [RULE1] with 16/17 prescaler: 4-bit swallow, 15-bit main; 47 or less forbidden
// [RULE2] aux power-down bit set stops aux loop and floats its pump
// [RULE3] auto power-up set: first-word write clears aux power-down
// [RULE4] chip enable low keeps aux loop off regardless of its bit
// [RULE5] aux reference divider is bits 15:4 of third word, 3 to 4095
// [RULE6] main pump gain bits 19:16, code k gives k+1 unit steps
// [RULE7] host must write the first five words before use
// [RULE8] access mask bits 23:20; bit 20 is one, others enable words
// [RULE9] optional word with mask bit clear is forced to defaults
// [RULE10] host writes each enabled optional word itself
// [RULE11] each optional word is accepted on its own
// [RULE12] fifth and sixth default all zero; seventh has bits 11, 8 set
// [RULE13] default optional fields all read zero, meaning disabled
// [RULE14] auto power-up clears both power-down bits, not with chip enable low
// [RULE15] 24-bit words, low nibble selects target, latched at end of shift
// [RULE16] writes to a masked-off optional word are dropped
module sac_cfg_regs (
	input  wire logic        i_ref_clk,      // core clock
	input  wire logic        i_rst,          // sync reset, high
	input  wire logic        i_ce,           // clock enable, freezes state
	input  wire logic        i_ser_clk,      // programming link clock
	input  wire logic        i_ser_data,     // programming serial data
	input  wire logic        i_ser_le,       // programming latch enable
	input  wire logic        i_chip_en,      // chip-enable pin, async
	output logic [18:0]      o_aux_n_div,    // aux divide word
	output logic [15:0]      o_aux_main_cnt, // aux main counter
	output logic [3:0]       o_aux_swallow,  // aux swallow counter
	output logic             o_aux_n_bad,    // aux divide value forbidden
	output logic             o_aux_loop_on,  // aux loop powered
	output logic             o_aux_pump_hiz, // aux pump floated
	output logic             o_main_pd_bit,  // main loop power-down bit
	output logic [11:0]      o_aux_ref_div,  // aux reference divide
	output logic             o_aux_ref_bad,  // reference below minimum
	output logic [3:0]       o_main_pump_gain, // main pump gain code
	output logic [4:0]       o_main_pump_mult, // gain as unit steps
	output logic [3:0]       o_access_mask,  // access mask
	output logic             o_access_bad,   // mask bit 20 not one
	output logic             o_auto_power_up, // auto power-up bit
	output logic             o_aux_pre16,    // aux 16/17 prescaler
	output sac_pkg::sac_opt_s o_opt,         // optional word fields
	output logic             o_cfg_ready     // first five words written
);

	sac_pkg::sac_bank_s st_r;
	sac_pkg::sac_bank_s st_nxt;
	logic [23:0]        link_word;
	logic               wr;
	logic [3:0]         sel;
	logic               sel_r0;
	logic [3:0]         mask;

	// link-domain shifter
	sac_link_shift u_shift (
		.i_ser_clk  (i_ser_clk),
		.i_ser_data (i_ser_data),
		.i_ser_le   (i_ser_le),
		.o_word     (link_word)
	);

	// word handed over when synced latch enable rises; the link is idle
	// then, so the shifter contents are stable while sampled here
	assign wr     = i_ce & st_r.le_s & ~st_r.le_d;
	assign sel    = link_word[sac_pkg::SEL_LSB +: sac_pkg::SEL_W];
	assign sel_r0 = ~link_word[sac_pkg::SEL_R0_POS];
	assign mask   = st_r.r3[sac_pkg::MASK_LSB +: sac_pkg::MASK_W];

	// next-state for the whole bank
	always_comb begin
		st_nxt = st_r;
		if (i_ce) begin
			// latch enable and chip enable pass two flops before any core-side use
			st_nxt.le_m  = i_ser_le;
			st_nxt.le_s  = st_r.le_m;
			st_nxt.le_d  = st_r.le_s;
			st_nxt.cen_m = i_chip_en;
			st_nxt.cen_s = st_r.cen_m;
		end
		// [RULE15] selector decode
		if (wr) begin
			unique case (sel)
				sac_pkg::SEL_R1: begin
					st_nxt.main_pd = link_word[sac_pkg::PD_POS];
					st_nxt.seen[1] = 1'b1;
				end
				sac_pkg::SEL_R2: begin
					st_nxt.aux_pd  = link_word[sac_pkg::PD_POS];
					st_nxt.aux_n   =
						link_word[sac_pkg::N_LSB +: sac_pkg::N_W];
					st_nxt.seen[2] = 1'b1;
				end
				sac_pkg::SEL_R3: begin
					st_nxt.r3      = link_word;
					st_nxt.seen[3] = 1'b1;
				end
				sac_pkg::SEL_R4: begin
					st_nxt.r4      = link_word;
					st_nxt.seen[4] = 1'b1;
				end
				// [RULE11] optional words taken one at a time
				// [RULE16] masked-off writes dropped
				sac_pkg::SEL_R5: begin
					if (mask[sac_pkg::MASK_R5]) begin
						st_nxt.r5 = link_word;
					end
				end
				sac_pkg::SEL_R6: begin
					if (mask[sac_pkg::MASK_R6]) begin
						st_nxt.r6 = link_word;
					end
				end
				sac_pkg::SEL_R7: begin
					if (mask[sac_pkg::MASK_R7]) begin
						st_nxt.r7 = link_word;
					end
				end
				default: begin
					// even codes: first word, main-loop word outside here
					if (sel_r0) begin
						st_nxt.seen[0] = 1'b1;
					end
				end
			endcase
			// [RULE3] auto power-up on first-word write
			// [RULE14] both loops, gated by chip enable
			if (sel_r0 && st_r.r4[sac_pkg::AUTO_POWER_UP_POS] && st_r.cen_s) begin
				st_nxt.aux_pd  = 1'b0;
				st_nxt.main_pd = 1'b0;
			end
		end
		// [RULE9] masked-off words held at defaults
		// [RULE12] default contents per word
		if (i_ce) begin
			if (!mask[sac_pkg::MASK_R5]) begin
				st_nxt.r5 = sac_pkg::R5_DEF;
			end
			if (!mask[sac_pkg::MASK_R6]) begin
				st_nxt.r6 = sac_pkg::R6_DEF;
			end
			if (!mask[sac_pkg::MASK_R7]) begin
				st_nxt.r7 = sac_pkg::R7_DEF;
			end
		end
		if (i_rst) begin
			st_nxt         = '0;
			st_nxt.aux_pd  = sac_pkg::PD_RST;
			st_nxt.main_pd = sac_pkg::PD_RST;
			st_nxt.aux_n   = sac_pkg::N_RST;
			st_nxt.r3      = sac_pkg::R3_RST;
			st_nxt.r4      = sac_pkg::R4_RST;
			st_nxt.r5      = sac_pkg::R5_DEF;
			st_nxt.r6      = sac_pkg::R6_DEF;
			st_nxt.r7      = sac_pkg::R7_DEF;
		end
	end

	// single state register; reset handled in the comb copy
	always_ff @(posedge i_ref_clk) begin
		st_r <= st_nxt;
	end

	// [RULE1] aux divide split by prescaler
	assign o_aux_pre16    = st_r.r4[sac_pkg::IFP_POS];
	assign o_aux_n_div    = st_r.aux_n;
	assign o_aux_swallow  = o_aux_pre16 ?
		st_r.aux_n[sac_pkg::A16_W-1:0] :
		{1'b0, st_r.aux_n[sac_pkg::A8_W-1:0]};
	assign o_aux_main_cnt = o_aux_pre16 ?
		{1'b0, st_r.aux_n[sac_pkg::N_W-1:sac_pkg::A16_W]} :
		st_r.aux_n[sac_pkg::N_W-1:sac_pkg::A8_W];
	assign o_aux_n_bad    = o_aux_pre16 &&
		(st_r.aux_n <= sac_pkg::N_PROHIB_MAX);

	// [RULE4] chip enable overrides the bit
	// [RULE2] off loop floats its pump
	assign o_aux_loop_on  = st_r.cen_s & ~st_r.aux_pd;
	assign o_aux_pump_hiz = ~o_aux_loop_on | o_opt.aux_pump_tristate;
	assign o_main_pd_bit  = st_r.main_pd;

	// [RULE5] reference field straight ratio
	assign o_aux_ref_div  = st_r.r3[sac_pkg::REF_LSB +: sac_pkg::REF_W];
	assign o_aux_ref_bad  = o_aux_ref_div < sac_pkg::REF_MIN;

	// [RULE6] pump gain as unit steps
	assign o_main_pump_gain =
		st_r.r3[sac_pkg::GAIN_LSB +: sac_pkg::GAIN_W];
	assign o_main_pump_mult = {1'b0, o_main_pump_gain} + 5'h01;

	// [RULE8] mask and its fixed bit
	assign o_access_mask  = mask;
	assign o_access_bad   = st_r.seen[3] & ~mask[sac_pkg::MASK_ONE];
	assign o_auto_power_up = st_r.r4[sac_pkg::AUTO_POWER_UP_POS];

	// [RULE13] defaults decode to zero fields
	// one process drives the whole struct, so it has a single driver
	always_comb begin
		o_opt = '0;
		o_opt.main_fraction_denominator = st_r.r5[sac_pkg::FD_LSB +: 10];
		o_opt.main_fraction_numerator   = st_r.r5[sac_pkg::FN_LSB +: 10];
		o_opt.cycle_slip_reduce         = st_r.r6[sac_pkg::CSR_LSB +: 2];
		o_opt.fastlock_pump_current     = st_r.r6[sac_pkg::CPF_LSB +: 4];
		o_opt.fastlock_timeout_count    = st_r.r6[sac_pkg::TOC_LSB +: 14];
		o_opt.lock_detect_divide_adjust = st_r.r7[sac_pkg::LOCK_DETECT_DIVIDE_ADJUST_POS];
		o_opt.aux_counter_reset         = st_r.r7[sac_pkg::ARST_POS];
		o_opt.main_counter_reset        = st_r.r7[sac_pkg::MRST_POS];
		o_opt.aux_pump_tristate         = st_r.r7[sac_pkg::ACPT_POS];
		o_opt.main_pump_tristate        = st_r.r7[sac_pkg::MCPT_POS];
	end

	// readiness only reports; use before it is the host's hazard
	assign o_cfg_ready = (st_r.seen == sac_pkg::SEEN_ALL);

	// checks on the core clock
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_first_word_auto;
		wr && sel_r0 && st_r.r4[sac_pkg::AUTO_POWER_UP_POS] && st_r.cen_s;
	endsequence

	sequence s_r5_masked_two;
		(!mask[sac_pkg::MASK_R5] && i_ce) ##1 !mask[sac_pkg::MASK_R5];
	endsequence

	sequence s_r7_masked_two;
		(!mask[sac_pkg::MASK_R7] && i_ce) ##1 !mask[sac_pkg::MASK_R7];
	endsequence

	sequence s_r6_masked_two;
		(!mask[sac_pkg::MASK_R6] && i_ce) ##1 !mask[sac_pkg::MASK_R6];
	endsequence

	// [RULE4] aux off with chip enable low
	chk_ce_low_off: assert property ( // [RULE4]
		!st_r.cen_s |-> !o_aux_loop_on)
		else $error("aux loop on while chip enable low");

	// [RULE2] powered-down loop floats pump
	chk_pd_pump_hiz: assert property ( // [RULE2]
		(st_r.aux_pd || !st_r.cen_s) |-> (o_aux_pump_hiz && !o_aux_loop_on))
		else $error("aux pump driven while powered down");

	// [RULE3] auto power-up clears aux bit
	chk_auto_pu_aux: assert property ( // [RULE3]
		s_first_word_auto |=> (!st_r.aux_pd ##1 1'b1))
		else $error("auto power-up left aux powered down");

	// [RULE14] both bits, none with chip enable low
	chk_auto_pu_both: assert property ( // [RULE14]
		s_first_word_auto |=> !st_r.main_pd &&
			(o_aux_loop_on || !st_r.cen_s))
		else $error("auto power-up missed a loop");

	chk_auto_pu_ce: assert property ( // [RULE14]
		(wr && sel_r0 && !st_r.cen_s) |=> $stable(st_r.aux_pd) &&
			$stable(st_r.main_pd))
		else $error("power-down bit changed with chip enable low");

	// [RULE9] masked word forced default
	chk_r5_default: assert property ( // [RULE9]
		s_r5_masked_two |-> (st_r.r5 == sac_pkg::R5_DEF))
		else $error("fifth word not at default while masked");

	// [RULE9] sixth word forced default
	chk_r6_default: assert property ( // [RULE9]
		s_r6_masked_two |-> (st_r.r6 == sac_pkg::R6_DEF))
		else $error("sixth word not at default while masked");

	// clock enable low holds every core flop
	chk_ce_freeze_all: assert property (
		!i_ce |=> $stable(st_r))
		else $error("core state moved with clock enable low");

	// [RULE12] seventh word default bits
	chk_r7_default: assert property ( // [RULE12]
		s_r7_masked_two |-> (st_r.r7 == sac_pkg::R7_DEF) &&
			!o_opt.main_pump_tristate && !o_opt.aux_pump_tristate)
		else $error("seventh word not at default while masked");

	// [RULE16] masked write dropped
	chk_masked_drop: assert property ( // [RULE16]
		(wr && sel == sac_pkg::SEL_R6 && !mask[sac_pkg::MASK_R6]) |=>
			(st_r.r6 == sac_pkg::R6_DEF))
		else $error("masked sixth word accepted data");

	// [RULE11] single fifth-word write leaves the sixth word
	chk_opt_single: assert property ( // [RULE11]
		(wr && sel == sac_pkg::SEL_R5 && mask[sac_pkg::MASK_R5] &&
			mask[sac_pkg::MASK_R6]) |=>
			(st_r.r5 == $past(link_word)) && $stable(st_r.r6))
		else $error("optional word write disturbed another");

	// [RULE5] reference field taken from bits 15:4
	chk_ref_field: assert property ( // [RULE5]
		(wr && sel == sac_pkg::SEL_R3) |=>
			(o_aux_ref_div == $past(link_word[15:4])))
		else $error("reference divider not from word bits");

	// [RULE6] gain steps are code plus one
	chk_gain_steps: assert property ( // [RULE6]
		(wr && sel == sac_pkg::SEL_R3) |=>
			(o_main_pump_mult == ({1'b0, $past(link_word[19:16])} + 5'h01)))
		else $error("pump steps not gain plus one");

	// [RULE1] forbidden range flagged with 16/17
	chk_n_forbidden: assert property ( // [RULE1]
		(o_aux_pre16 && st_r.aux_n < 19'h00030) |-> o_aux_n_bad)
		else $error("forbidden aux divide not flagged");

endmodule // sac_cfg_regs

// File: rtl/sac_link_shift.sv
// serial shifter clocked by the programming link clock
module sac_link_shift (
	input  wire logic        i_ser_clk,   // link clock from host
	input  wire logic        i_ser_data,  // serial data, msb first
	input  wire logic        i_ser_le,    // latch enable, high ends word
	output logic [23:0]      o_word       // last 24 bits shifted
);

	sac_pkg::sac_sh_s st_r;
	sac_pkg::sac_sh_s st_nxt;

	// shift only while latch enable is low; word holds while it is high
	always_comb begin
		st_nxt = st_r;
		if (!i_ser_le) begin
			st_nxt.sh = {st_r.sh[22:0], i_ser_data};
		end
	end

	// no reset: the link clock may stand still, contents are data only
	always_ff @(posedge i_ser_clk) begin
		st_r <= st_nxt;
	end

	assign o_word = st_r.sh;

endmodule // sac_link_shift

// File: rtl/sac_pkg.sv
// constants, layouts and carriers for the synthesizer control-word bank
package sac_pkg;

	// control word framing
	localparam int WORD_W = 24;
	localparam int SEL_W  = 4;
	localparam int DATA_W = 20;
	localparam int SEL_LSB = 0;

	// target selectors carried in the low nibble
	localparam logic [3:0] SEL_R1 = 4'h3;
	localparam logic [3:0] SEL_R2 = 4'h5;
	localparam logic [3:0] SEL_R3 = 4'h7;
	localparam logic [3:0] SEL_R4 = 4'h9;
	localparam logic [3:0] SEL_R5 = 4'hb;
	localparam logic [3:0] SEL_R6 = 4'hd;
	localparam logic [3:0] SEL_R7 = 4'hf;
	localparam int SEL_R0_POS = 0;   // first word: this bit reads zero

	// power-down bit shared by the main and aux loop words
	localparam int PD_POS = 23;

	// aux divide word
	localparam int N_LSB = 4;
	localparam int N_W   = 19;
	localparam int A16_W = 4;        // swallow width with 16/17
	localparam int A8_W  = 3;        // swallow width with 8/9
	localparam logic [18:0] N_PROHIB_MAX = 19'h0002f;

	// third word fields
	localparam int REF_LSB  = 4;
	localparam int REF_W    = 12;
	localparam int GAIN_LSB = 16;
	localparam int GAIN_W   = 4;
	localparam int MASK_LSB = 20;
	localparam int MASK_W   = 4;
	localparam int MASK_ONE = 0;     // must be written as one
	localparam int MASK_R5  = 1;
	localparam int MASK_R6  = 2;
	localparam int MASK_R7  = 3;
	localparam logic [11:0] REF_MIN = 12'h003;

	// general config bits used here
	localparam int AUTO_POWER_UP_POS = 23;
	localparam int IFP_POS  = 8;

	// optional word field positions
	localparam int FD_LSB  = 14;
	localparam int FN_LSB  = 4;
	localparam int CSR_LSB = 22;
	localparam int CPF_LSB = 18;
	localparam int TOC_LSB = 4;
	localparam int LOCK_DETECT_DIVIDE_ADJUST_POS = 13;
	localparam int ARST_POS = 7;
	localparam int MRST_POS = 6;
	localparam int ACPT_POS = 5;
	localparam int MCPT_POS = 4;

	// forced defaults and reset contents
	localparam logic [23:0] R5_DEF = 24'h00000b;
	localparam logic [23:0] R6_DEF = 24'h00000d;
	localparam logic [23:0] R7_DEF = 24'h00090f;
	localparam logic [23:0] R3_RST = 24'h000007;
	localparam logic [23:0] R4_RST = 24'h000009;
	localparam logic [18:0] N_RST  = 19'h00000;
	localparam logic        PD_RST = 1'b1;
	localparam logic [4:0]  SEEN_ALL = 5'h1f;

	// decoded optional-word fields
	typedef struct packed {
		logic [9:0]  main_fraction_denominator;
		logic [9:0]  main_fraction_numerator;
		logic [1:0]  cycle_slip_reduce;
		logic [3:0]  fastlock_pump_current;
		logic [13:0] fastlock_timeout_count;
		logic        lock_detect_divide_adjust;
		logic        aux_counter_reset;
		logic        main_counter_reset;
		logic        aux_pump_tristate;
		logic        main_pump_tristate;
	} sac_opt_s;

	// link-side shifter state
	typedef struct packed {
		logic [23:0] sh;
	} sac_sh_s;

	// bank state
	typedef struct packed {
		logic        le_m;
		logic        le_s;
		logic        le_d;
		logic        cen_m;
		logic        cen_s;
		logic        aux_pd;
		logic        main_pd;
		logic [18:0] aux_n;
		logic [23:0] r3;
		logic [23:0] r4;
		logic [23:0] r5;
		logic [23:0] r6;
		logic [23:0] r7;
		logic [4:0]  seen;
	} sac_bank_s;

endpackage : sac_pkg

// File: verification/sac_host_model.sv
// host model: shifts control words out on the three-wire link
module sac_host_model (
	output logic o_ser_clk,  // link clock, still between words
	output logic o_ser_data, // serial data, msb first
	output logic o_ser_le    // latch enable, high ends a word
);
	timeunit 1ns;
	timeprecision 1ps;

	// link idles with clock low and latch low
	initial begin
		o_ser_clk  = 1'b0;
		o_ser_data = 1'b0;
		o_ser_le   = 1'b0;
	end

	// caller sends each enabled optional word itself
	task automatic send(input logic [23:0] w);
		#1; // odd offset keeps link edges off the core edges
		for (int i = 23; i >= 0; i--) begin
			o_ser_data = w[i];
			#6 o_ser_clk = 1'b1;
			#6 o_ser_clk = 1'b0;
		end
		// idle data is inverted so a stale bit never looks valid
		o_ser_data = ~w[0];
		o_ser_le   = 1'b1;
		#48 o_ser_le = 1'b0; // twelve ref cycles high, clock still
		#23;                 // word spacing stays a whole core period
	endtask
endmodule // sac_host_model

// File: verification/testbench.sv
// self-checking bench for the synthesizer control-word bank
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int LIMIT = 10000; // about three times the expected run

	logic              i_ref_clk;
	logic              i_rst;
	logic              i_ce;
	logic              i_chip_en;
	logic              i_ser_clk;
	logic              i_ser_data;
	logic              i_ser_le;
	logic [18:0]       o_aux_n_div;
	logic [15:0]       o_aux_main_cnt;
	logic [3:0]        o_aux_swallow;
	logic              o_aux_n_bad;
	logic              o_aux_loop_on;
	logic              o_aux_pump_hiz;
	logic              o_main_pd_bit;
	logic [11:0]       o_aux_ref_div;
	logic              o_aux_ref_bad;
	logic [3:0]        o_main_pump_gain;
	logic [4:0]        o_main_pump_mult;
	logic [3:0]        o_access_mask;
	logic              o_access_bad;
	logic              o_auto_power_up;
	logic              o_aux_pre16;
	sac_pkg::sac_opt_s o_opt;
	logic              o_cfg_ready;
	int                fails;
	int                n_tests;
	int                cyc = 0;
	logic [18:0]       nv [4] = '{19'd47, 19'd48, 19'd241, 19'h7ffff};

	sac_host_model host (
		.o_ser_clk  (i_ser_clk),
		.o_ser_data (i_ser_data),
		.o_ser_le   (i_ser_le)
	);

	sac_cfg_regs uut (
		.i_ref_clk        (i_ref_clk),
		.i_rst            (i_rst),
		.i_ce             (i_ce),
		.i_ser_clk        (i_ser_clk),
		.i_ser_data       (i_ser_data),
		.i_ser_le         (i_ser_le),
		.i_chip_en        (i_chip_en),
		.o_aux_n_div      (o_aux_n_div),
		.o_aux_main_cnt   (o_aux_main_cnt),
		.o_aux_swallow    (o_aux_swallow),
		.o_aux_n_bad      (o_aux_n_bad),
		.o_aux_loop_on    (o_aux_loop_on),
		.o_aux_pump_hiz   (o_aux_pump_hiz),
		.o_main_pd_bit    (o_main_pd_bit),
		.o_aux_ref_div    (o_aux_ref_div),
		.o_aux_ref_bad    (o_aux_ref_bad),
		.o_main_pump_gain (o_main_pump_gain),
		.o_main_pump_mult (o_main_pump_mult),
		.o_access_mask    (o_access_mask),
		.o_access_bad     (o_access_bad),
		.o_auto_power_up  (o_auto_power_up),
		.o_aux_pre16      (o_aux_pre16),
		.o_opt            (o_opt),
		.o_cfg_ready      (o_cfg_ready)
	);

	// core clock, 4 ns
	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end

	// hang guard counts core cycles
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask

	// chip enable moves on a core edge, then the sync settles
	task automatic set_ce_pin(input logic v);
		@(posedge i_ref_clk);
		i_chip_en <= v;
		repeat (4) @(posedge i_ref_clk);
	endtask

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		fails = 0;
		n_tests = 0;
		i_rst = 1'b1;
		i_ce = 1'b1;
		i_chip_en = 1'b1;
		repeat (8) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		chk(48'(o_aux_loop_on), 48'h0);
		chk(48'(o_aux_pump_hiz), 48'h1);
		chk(48'(o_opt), 48'h0);
		chk(48'(o_cfg_ready), 48'h0);
		$display("test reset values done");

		// every gain code, largest reference divide
		for (int k = 0; k < 16; k++) begin
			host.send({4'h1, 4'(k), 12'hfff, sac_pkg::SEL_R3});
			chk(48'(o_main_pump_gain), 48'(k));
			chk(48'(o_main_pump_mult), 48'(k + 1));
			chk(48'(o_aux_ref_div), 48'hfff);
		end
		// frozen core misses a whole word
		@(posedge i_ref_clk);
		i_ce <= 1'b0;
		host.send({4'h1, 4'h5, 12'h123, sac_pkg::SEL_R3});
		chk(48'(o_main_pump_gain), 48'hf);
		@(posedge i_ref_clk);
		i_ce <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		chk(48'(o_aux_ref_div), 48'hfff);
		chk(48'(o_access_mask), 48'h1);
		host.send({4'h1, 4'h0, 12'h003, sac_pkg::SEL_R3});
		chk(48'(o_aux_ref_bad), 48'h0);
		chk(48'(o_access_bad), 48'h0);
		host.send({4'h0, 4'h0, 12'h002, sac_pkg::SEL_R3});
		chk(48'(o_aux_ref_bad), 48'h1);
		chk(48'(o_access_bad), 48'h1);
		$display("test third word done");

		// aux divide split with the 16/17 prescaler
		host.send(24'h000109);
		chk(48'(o_aux_pre16), 48'h1);
		foreach (nv[i]) begin
			host.send({1'b1, nv[i], sac_pkg::SEL_R2});
			chk(48'(o_aux_n_bad), 48'(nv[i] <= 19'd47));
			chk(48'(o_aux_main_cnt), 48'(nv[i][18:4]));
			chk(48'(o_aux_swallow), 48'(nv[i][3:0]));
			chk(48'(o_aux_n_div), 48'(nv[i]));
		end
		// 8/9 prescaler: 3-bit swallow, never flagged
		host.send(24'h000009);
		host.send({1'b1, 19'd41, sac_pkg::SEL_R2});
		chk(48'(o_aux_pre16), 48'h0);
		chk(48'(o_aux_n_bad), 48'h0);
		chk(48'(o_aux_main_cnt), 48'(19'd41 >> 3));
		chk(48'(o_aux_swallow), 48'(19'd41 & 19'h7));
		$display("test aux divide done");

		// power-down bit and chip-enable override
		host.send({1'b0, 19'd240, sac_pkg::SEL_R2});
		chk(48'(o_aux_loop_on), 48'h1);
		chk(48'(o_aux_pump_hiz), 48'h0);
		set_ce_pin(1'b0);
		chk(48'(o_aux_loop_on), 48'h0);
		chk(48'(o_aux_pump_hiz), 48'h1);
		set_ce_pin(1'b1);
		host.send({1'b1, 19'd240, sac_pkg::SEL_R2});
		chk(48'(o_aux_loop_on), 48'h0);
		host.send({1'b1, 19'd0, sac_pkg::SEL_R1});
		chk(48'(o_main_pd_bit), 48'h1);
		host.send(24'h800109);
		chk(48'(o_auto_power_up), 48'h1);
		// first word with the pin low must not power up
		set_ce_pin(1'b0);
		host.send(24'h000000);
		set_ce_pin(1'b1);
		chk(48'(o_aux_loop_on), 48'h0);
		chk(48'(o_main_pd_bit), 48'h1);
		host.send(24'h000000);
		chk(48'(o_aux_loop_on), 48'h1);
		chk(48'(o_main_pd_bit), 48'h0);
		chk(48'(o_cfg_ready), 48'h1);
		$display("test power control done");

		// optional words: masked writes, single updates, defaults
		host.send(24'hfffffb);
		chk(48'(o_opt), 48'h0);
		host.send(24'hfffffd);
		chk(48'(o_opt), 48'h0);
		host.send(24'h300037);
		host.send(24'h80001b);
		chk(48'(o_opt.main_fraction_denominator), 48'h200);
		chk(48'(o_opt.main_fraction_numerator), 48'h001);
		host.send(24'hf00037);
		host.send(24'hc0000d);
		chk(48'(o_opt.cycle_slip_reduce), 48'h3);
		host.send(24'h00002f);
		chk(48'(o_opt.aux_pump_tristate), 48'h1);
		chk(48'(o_aux_pump_hiz), 48'h1);
		chk(48'(o_opt.main_fraction_denominator), 48'h200);
		host.send(24'h40001b);
		chk(48'(o_opt.main_fraction_denominator), 48'h100);
		chk(48'(o_opt.cycle_slip_reduce), 48'h3);
		host.send(24'h100037);
		repeat (3) @(posedge i_ref_clk);
		chk(48'(o_opt), 48'h0);
		chk(48'(o_aux_pump_hiz), 48'h0);
		$display("test optional words done");

		// second reset in mid-run restores the power-up state
		@(posedge i_ref_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		chk(48'(o_aux_loop_on), 48'h0);
		chk(48'(o_main_pd_bit), 48'h1);
		chk(48'(o_cfg_ready), 48'h0);
		chk(48'(o_access_mask), 48'h0);
		chk(48'(o_opt), 48'h0);
		$display("test mid-run reset done");
		report_and_stop();
	end
endmodule // testbench
